// ### hdl/iflp_consts.svh
// Constants shared by both ends of the interrupt level/priority link.
// Assumes byte addressing on the link and APB word addressing on the core end.
`ifndef IFLP_CONSTS_SVH
`define IFLP_CONSTS_SVH

// ----------------------------------------------------------------------
// Link map of the controller, byte offsets
// ----------------------------------------------------------------------
`define IFLP_OFF_PEND 8'h00
`define IFLP_OFF_MASK 8'h08
`define IFLP_OFF_LVL 8'h18
`define IFLP_OFF_ICR 8'h40
`define IFLP_OFF_ICR_END 8'h7F
`define IFLP_OFF_SWACK 8'hE0
`define IFLP_OFF_LACK1 8'hE4
`define IFLP_BLK_MASK 8'hF8

// ----------------------------------------------------------------------
// Vectors, fixed sources, transfer encoding
// ----------------------------------------------------------------------
`define IFLP_VEC_BASE0 8'h40
`define IFLP_VEC_BASE1 8'h80
`define IFLP_VEC_SPUR 8'h18
`define IFLP_FIRST_PROG 6'h08
`define IFLP_NUM_SRC 63
`define IFLP_SCORE_FIXED 4'h5
`define IFLP_MASK_RST 64'hFFFF_FFFF_FFFF_FFFF
`define IFLP_TT_VECTOR_FETCH_CYCLE 2'h3
`define IFLP_TM_VECTOR_FETCH_CYCLE 3'h1
`define IFLP_TT_NORM 2'h0
`define IFLP_LVL_NMI 3'h7

// ----------------------------------------------------------------------
// Core end APB map and field positions
// ----------------------------------------------------------------------
`define IFLP_APB_CMD 12'h000
`define IFLP_APB_STAT 12'h004
`define IFLP_APB_SRMASK 12'h008
`define IFLP_CMD_WR_BIT 16
`define IFLP_CMD_VECTOR_FETCH_CYCLE_BIT 17
`define IFLP_STAT_BUSY_BIT 24

`endif

// ### hdl/iflp_pkg.sv
// Types shared by both ends of the interrupt level/priority link.
// Assumes nothing beyond the constants header.
package iflp_pkg;
    typedef logic [2:0] iflp_lvl_t;
    typedef logic [5:0] iflp_src_t;
    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} iflp_core_st_t;
endpackage

// ### hdl/iflp_link_if.sv
// Link between the interrupt controller and the processor core end.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface iflp_link_if;
    logic [2:0] ipl;    // Encoded request level, 0 = none
    logic req;          // Access request, held until done
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [1:0] tt;     // Transfer type
    logic [2:0] tm;     // Transfer modifier
    logic done;         // One-cycle answer
    logic [7:0] rdata;
    modport dev (output ipl, done, rdata, input req, we, addr, wdata, tt, tm);
    modport core (input ipl, done, rdata, output req, we, addr, wdata, tt, tm);
endinterface
`default_nettype wire

// ### hdl/iflp_ctrl.sv
// Interrupt controller: 63 request lines, per-source level and priority,
// masking, decoded and encoded level, vector answer for acknowledges.
// Assumes the core end holds a link request until done and that
// peripherals keep requests up until serviced.
`timescale 1ns/1ps
`default_nettype none
`include "iflp_consts.svh"

// Notes on behaviour
// - 63 sources, 56 programmable, 7 fixed
// - Own 8-bit control byte, level and priority
// - Every source has its own vector
// - Per-source mask plus one mask-all bit
// - Hardware and software acknowledges both answered
// - Wake-up output while any request active
// - Three-bit encoded level, 7 highest, 0 none
// - Core takes level above its mask field
// - Core: level 7 edge, 1-6 level, maskable
// - Peripheral holds request until service clears it
// - Acknowledge byte read by special transfer encoding
// - User vectors lie in 64 to 255
// - Acknowledge never touches or clears the peripheral
// - Seven levels, up to nine requests each
// - Codes 111-100 over fixed, fixed over 011-000
// - Sources 1-7 fixed at own level midpoint
// - Software puts at most eight per level
// - Requests evaluated continuously against masks
// - Decoded 7-bit level, ORed, highest encoded
// - Acknowledged level from address bits 4:2
// - Vector is base 64 or 128 plus source
// - No request at level returns vector 24
module iflp_ctrl
    import iflp_pkg::*;
#(
    parameter bit SECOND = 1'b0
)
(
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    iflp_link_if.dev LINK,
    input wire logic [63:1] SRC_REQ_IN,
    input wire logic [7:1] LEVEL_VEC_IN,
    output logic [7:1] LEVEL_VEC_OUT,
    output logic WAKEUP_OUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] icr [8:63];     // Control bytes of programmable sources
    logic [63:0] mask;          // Bit 0 masks all
    logic [63:1] active;
    logic [7:1] dec_lvl;
    logic [7:0] next_rdata;
    logic [7:0] vec_base;

    assign vec_base = SECOND ? `IFLP_VEC_BASE1 : `IFLP_VEC_BASE0;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Level of a source; sources 1-7 are wired to their own level
    function automatic iflp_lvl_t src_level(input iflp_src_t n);
        if (n < `IFLP_FIRST_PROG)
        begin
            src_level = n[2:0];
        end
        else
        begin
            src_level = icr[n][5:3];
        end
    endfunction

    // Rank within a level; the fixed source sits between codes 011 and 100
    function automatic logic [3:0] src_score(input iflp_src_t n);
        logic [2:0] p;
        p = icr[(n < `IFLP_FIRST_PROG) ? `IFLP_FIRST_PROG : n][2:0];
        if (n < `IFLP_FIRST_PROG)
        begin
            src_score = `IFLP_SCORE_FIXED;
        end
        else if (p[2])
        begin
            src_score = {1'b0, p} + 4'h2;
        end
        else
        begin
            src_score = {1'b0, p} + 4'h1;
        end
    endfunction

    // Highest ranked active source at a level, 0 when none
    function automatic iflp_src_t best_src(input iflp_lvl_t l);
        logic [3:0] top;
        best_src = 6'h00;
        top = 4'h0;
        for (int i = 1; i <= `IFLP_NUM_SRC; i++)
        begin
            if (active[i] && src_level(6'(i)) == l && src_score(6'(i)) > top)
            begin
                top = src_score(6'(i));
                best_src = 6'(i);
            end
        end
    endfunction

    // Vector for an acknowledged level
    function automatic logic [7:0] ack_vector(input iflp_lvl_t l);
        iflp_src_t s;
        s = best_src(l);
        if (s == 6'h00 || l == 3'h0)
        begin
            ack_vector = `IFLP_VEC_SPUR;
        end
        else
        begin
            ack_vector = vec_base + {2'b00, s};
        end
    endfunction

    // Highest set bit of a decoded level vector
    function automatic iflp_lvl_t enc_level(input logic [7:1] v);
        enc_level = 3'h0;
        for (int i = 1; i <= 7; i++)
        begin
            if (v[i])
            begin
                enc_level = 3'(i);
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Recognition and prioritisation, evaluated every cycle
    // ------------------------------------------------------------------
    // Masked requests never reach a level or a vector
    assign active = SRC_REQ_IN & ~mask[63:1] & {63{~mask[0]}};

    always_comb
    begin
        dec_lvl = 7'h00;
        for (int i = 1; i <= `IFLP_NUM_SRC; i++)
        begin
            if (active[i] && src_level(6'(i)) != 3'h0)
            begin
                dec_lvl[src_level(6'(i))] = 1'b1;
            end
        end
    end

    // Level outputs registered; the encoded level includes the cascade input
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            LEVEL_VEC_OUT <= 7'h00;
            LINK.ipl <= 3'h0;
            WAKEUP_OUT <= 1'b0;
        end
        else
        begin
            LEVEL_VEC_OUT <= dec_lvl;
            LINK.ipl <= enc_level(dec_lvl | LEVEL_VEC_IN);
            WAKEUP_OUT <= |active;
        end
    end

    // ------------------------------------------------------------------
    // Link read decode
    // ------------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        if (LINK.tt == `IFLP_TT_VECTOR_FETCH_CYCLE && LINK.tm == `IFLP_TM_VECTOR_FETCH_CYCLE)
        begin
            next_rdata = ack_vector(LINK.addr[4:2]);
        end
        else if (LINK.addr == `IFLP_OFF_SWACK)
        begin
            next_rdata = ack_vector(enc_level(dec_lvl));
        end
        else if (LINK.addr >= `IFLP_OFF_LACK1)
        begin
            next_rdata = ack_vector(LINK.addr[4:2]);
        end
        else if ((LINK.addr & `IFLP_BLK_MASK) == `IFLP_OFF_PEND)
        begin
            next_rdata = 8'({active, 1'b0} >> {LINK.addr[2:0], 3'b000});
        end
        else if ((LINK.addr & `IFLP_BLK_MASK) == `IFLP_OFF_MASK)
        begin
            next_rdata = mask[{LINK.addr[2:0], 3'b000} +: 8];
        end
        else if (LINK.addr == `IFLP_OFF_LVL)
        begin
            next_rdata = {dec_lvl, 1'b0};
        end
        else if (LINK.addr >= `IFLP_OFF_ICR && LINK.addr <= `IFLP_OFF_ICR_END)
        begin
            if (LINK.addr[5:0] < `IFLP_FIRST_PROG)
            begin
                next_rdata = {2'b00, LINK.addr[2:0], 3'b000};
            end
            else
            begin
                next_rdata = icr[LINK.addr[5:0]];
            end
        end
    end

    // ------------------------------------------------------------------
    // Link answer: one cycle after the request is seen
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            LINK.done <= 1'b0;
            LINK.rdata <= 8'h00;
        end
        else
        begin
            LINK.done <= LINK.req && !LINK.done;
            if (LINK.req && !LINK.done && !LINK.we)
            begin
                LINK.rdata <= next_rdata;
            end
        end
    end

    // Writes; fixed sources have no storage and ignore writes
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            mask <= `IFLP_MASK_RST;
            for (int i = 8; i <= 63; i++)
            begin
                icr[i] <= 8'h00;
            end
        end
        else if (LINK.req && !LINK.done && LINK.we && LINK.tt == `IFLP_TT_NORM)
        begin
            if ((LINK.addr & `IFLP_BLK_MASK) == `IFLP_OFF_MASK)
            begin
                mask[{LINK.addr[2:0], 3'b000} +: 8] <= LINK.wdata;
            end
            else if (LINK.addr >= `IFLP_OFF_ICR && LINK.addr <= `IFLP_OFF_ICR_END &&
                     LINK.addr[5:0] >= `IFLP_FIRST_PROG)
            begin
                icr[LINK.addr[5:0]] <= LINK.wdata;
            end
        end
    end

endmodule
`default_nettype wire

// ### hdl/iflp_core.sv
// Core end of the link: samples the encoded level at instruction
// boundaries, runs acknowledge fetches, and forwards software accesses.
// Assumes an APB master on the software side and one controller on the link.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iflp_consts.svh"
module iflp_core
    import iflp_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    iflp_link_if.core LINK,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic INSN_BOUNDARY_IN,
    output logic EXC_TAKEN_OUT,
    output logic [7:0] EXC_VECTOR_OUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    iflp_core_st_t state;
    logic [17:0] cmd;       // Pending software access
    logic cmd_pend;
    logic auto_ack;         // Current access is a hardware acknowledge
    iflp_lvl_t srmask;      // Mask field of core_status_word
    iflp_lvl_t ack_lvl;
    logic nmi_armed;        // Level 7 taken only on a fresh edge
    logic [7:0] last_rdata;
    logic take;
    logic busy;
    logic apb_acc;
    logic apb_setup;
    logic cmd_hit;

    assign busy = cmd_pend || state != ST_IDLE;
    assign apb_setup = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    assign apb_acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign cmd_hit = PWRITE_IN && PADDR_IN == `IFLP_APB_CMD;
    // Level 7 ignores the mask but only once per rising edge
    assign take = INSN_BOUNDARY_IN && ((LINK.ipl == `IFLP_LVL_NMI) ? nmi_armed :
                                       (LINK.ipl > srmask));

    // ------------------------------------------------------------------
    // Link access sequencer
    // ------------------------------------------------------------------
    // Hardware acknowledge wins over a queued software access
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            state <= ST_IDLE;
            auto_ack <= 1'b0;
            ack_lvl <= 3'h0;
            LINK.req <= 1'b0;
            LINK.we <= 1'b0;
            LINK.addr <= 8'h00;
            LINK.wdata <= 8'h00;
            LINK.tt <= `IFLP_TT_NORM;
            LINK.tm <= 3'h0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        state <= ST_WAIT;
                        auto_ack <= 1'b1;
                        ack_lvl <= LINK.ipl;
                        LINK.req <= 1'b1;
                        LINK.we <= 1'b0;
                        LINK.addr <= {`IFLP_OFF_SWACK} | {3'b000, LINK.ipl, 2'b00};
                        LINK.tt <= `IFLP_TT_VECTOR_FETCH_CYCLE;
                        LINK.tm <= `IFLP_TM_VECTOR_FETCH_CYCLE;
                    end
                    else if (cmd_pend)
                    begin
                        state <= ST_WAIT;
                        auto_ack <= 1'b0;
                        LINK.req <= 1'b1;
                        LINK.we <= cmd[`IFLP_CMD_WR_BIT];
                        LINK.addr <= cmd[7:0];
                        LINK.wdata <= cmd[15:8];
                        LINK.tt <= cmd[`IFLP_CMD_VECTOR_FETCH_CYCLE_BIT] ? `IFLP_TT_VECTOR_FETCH_CYCLE : `IFLP_TT_NORM;
                        LINK.tm <= cmd[`IFLP_CMD_VECTOR_FETCH_CYCLE_BIT] ? `IFLP_TM_VECTOR_FETCH_CYCLE : 3'h0;
                    end
                end
                ST_WAIT:
                begin
                    if (LINK.done)
                    begin
                        state <= ST_IDLE;
                        LINK.req <= 1'b0;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Acknowledge results and the mask raise that follows a taken level
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            EXC_TAKEN_OUT <= 1'b0;
            EXC_VECTOR_OUT <= 8'h00;
            last_rdata <= 8'h00;
            srmask <= 3'h7;
        end
        else
        begin
            EXC_TAKEN_OUT <= 1'b0;
            if (state == ST_WAIT && LINK.done)
            begin
                last_rdata <= LINK.rdata;
                if (auto_ack)
                begin
                    EXC_TAKEN_OUT <= 1'b1;
                    EXC_VECTOR_OUT <= LINK.rdata;
                    srmask <= ack_lvl;
                end
            end
            else if (apb_acc && PWRITE_IN && PADDR_IN == `IFLP_APB_SRMASK)
            begin
                srmask <= PWDATA_IN[10:8];
            end
        end
    end

    // Edge detect for level 7; a fresh edge rearms only after it drops
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            nmi_armed <= 1'b1;
        end
        else if (LINK.ipl != `IFLP_LVL_NMI)
        begin
            nmi_armed <= 1'b1;
        end
        else if (state == ST_IDLE && take)
        begin
            nmi_armed <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end
        else
        begin
            PREADY_OUT <= apb_setup;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            if (apb_setup)
            begin
                if (cmd_hit)
                begin
                    PSLVERR_OUT <= busy; // Refused while an access is outstanding
                end
                else if (!PWRITE_IN && PADDR_IN == `IFLP_APB_STAT)
                begin
                    PRDATA_OUT <= {7'h00, busy, 5'h00, LINK.ipl, EXC_VECTOR_OUT, last_rdata};
                end
                else if (PADDR_IN == `IFLP_APB_SRMASK)
                begin
                    PRDATA_OUT <= {21'h000000, srmask, 8'h00};
                end
                else if (PADDR_IN != `IFLP_APB_CMD)
                begin
                    PSLVERR_OUT <= 1'b1;
                end
            end
        end
    end

    // Command capture at the completing edge; busy writes are dropped
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            cmd <= 18'h00000;
            cmd_pend <= 1'b0;
        end
        else if (apb_acc && cmd_hit && !PSLVERR_OUT)
        begin
            cmd <= PWDATA_IN[17:0];
            cmd_pend <= 1'b1;
        end
        else if (state == ST_IDLE && !take)
        begin
            cmd_pend <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### dv/iflp_checker.sv
// Checker on the link between controller and core end.
// Assumes it sits beside the link interface, same clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "iflp_consts.svh"
module iflp_checker
(
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    input wire logic [2:0] ipl,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [1:0] tt,
    input wire logic [2:0] tm,
    input wire logic done,
    input wire logic [7:0] rdata
);
    // ----------------------------------------------------------------
    // Link handshake and vector answers
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    logic ack_rd;
    // Completed read carrying the acknowledge encoding
    assign ack_rd = req && done && !we && tt == `IFLP_TT_VECTOR_FETCH_CYCLE && tm == `IFLP_TM_VECTOR_FETCH_CYCLE;
    property p_done_next;
        $rose(req) |=> done;
    endproperty
    a_done_next: assert property (p_done_next) else $error("done late");
    property p_done_pulse;
        done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done long");
    property p_done_req;
        done |-> req;
    endproperty
    a_done_req: assert property (p_done_req) else $error("done without req");
    property p_req_hold;
        req && !done |=> req && $stable(addr) && $stable(we) && $stable(wdata) && $stable(tt);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    property p_req_drop;
        done |=> !req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("req held");
    property p_rdata_hold;
        done && !we |=> $stable(rdata) [*2];
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    property p_vec_range;
        ack_rd |-> rdata == `IFLP_VEC_SPUR || rdata >= 8'h40;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");
    property p_lvl0_spur;
        ack_rd && addr[4:2] == 3'h0 |-> rdata == `IFLP_VEC_SPUR;
    endproperty
    a_lvl0_spur: assert property (p_lvl0_spur) else $error("level 0 not spurious");
    c_nmi: cover property (ipl == 3'h7);
endmodule
`default_nettype wire

// ### dv/interrupt_level_priority_controller_test.sv
// Bench: controller and core end joined by the link, driven over APB.
// Assumes the hdl/ files are compiled first; one controller, base 64.
`timescale 1ns/1ps
`default_nettype none
`include "iflp_consts.svh"
module interrupt_level_priority_controller_test import iflp_pkg::*;;
    // ----------------------------------------------------------------
    // Clock, stimulus signals and design
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic insn = 1'b0;
    logic [63:1] src = '0;
    logic [7:1] lvin = '0;
    logic [31:0] prdata, q;
    logic pready, pslverr, exc, wake, e;
    logic [7:0] excv, r;
    logic [7:1] lvout;
    logic [63:0] mreg, pv;
    int fail_count = 0;
    int check_count = 0;
    int lv[64], pr[64];
    int k, m, l, n, tk;
    // Free-running system clock
    always #5 clk = ~clk;
    iflp_link_if link ();
    iflp_ctrl #(.SECOND(1'b0)) iflp_ctrl_i (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .LINK(link),
        .SRC_REQ_IN(src), .LEVEL_VEC_IN(lvin), .LEVEL_VEC_OUT(lvout), .WAKEUP_OUT(wake));
    iflp_core iflp_core_i (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .LINK(link), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .INSN_BOUNDARY_IN(insn), .EXC_TAKEN_OUT(exc), .EXC_VECTOR_OUT(excv));
    iflp_checker iflp_checker_i (.CLK_SYS_IN(clk), .ARST_N_IN(arst_n), .ipl(link.ipl),
        .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .tt(link.tt),
        .tm(link.tm), .done(link.done), .rdata(link.rdata));
    // ----------------------------------------------------------------
    // Bus tasks and reference model
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer; an idle cycle follows so psel never toggles twice per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // Link access through the command register, then poll until idle
    task automatic lk(input logic w, input logic [7:0] a, input logic [7:0] d, input logic ak,
        output logic [7:0] rd);
        logic [31:0] s;
        logic er;
        int c;
        apb(1'b1, `IFLP_APB_CMD, {14'h0, ak, w, d, a}, s, er);
        c = 0;
        do
        begin
            apb(1'b0, `IFLP_APB_STAT, 32'h0, s, er);
            c++;
        end
        while (s[`IFLP_STAT_BUSY_BIT] !== 1'b0 && c < 50);
        if (c >= 50) fail_count++;
        rd = s[7:0];
    endtask
    function automatic int lvl_of(int s);
        return s < 8 ? s : lv[s];
    endfunction
    // Fixed sources sit between codes 3 and 4
    function automatic int score(int s);
        return s < 8 ? 4 : (pr[s] > 3 ? pr[s] + 1 : pr[s]);
    endfunction
    function automatic bit act(int s);
        return src[s] === 1'b1 && !mreg[s] && !mreg[0];
    endfunction
    function automatic int vec(int lq);
        int b;
        int v;
        b = -1;
        v = 24;
        for (int s = 1; s < 64; s++)
            if (lq != 0 && act(s) && lvl_of(s) == lq && score(s) > b)
            begin
                b = score(s);
                v = 64 + s;
            end
        return v;
    endfunction
    function automatic logic [7:1] dec();
        logic [7:1] d;
        d = '0;
        for (int s = 1; s < 64; s++)
            if (act(s) && lvl_of(s) != 0) d[lvl_of(s)] = 1'b1;
        return d;
    endfunction
    function automatic int top(logic [7:1] d);
        for (int i = 7; i > 0; i--)
            if (d[i]) return i;
        return 0;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    // Watchdog well above the expected run length
    initial
    begin
        #400000;
        fail_count++;
        results();
    end
    // Main sequence: reset values and refusals, then random rounds
    initial
    begin
        void'($urandom(52954));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        lk(1'b0, `IFLP_OFF_MASK, 8'h00, 1'b0, r);
        chk("mask reset", 8'hFF, r);
        lk(1'b0, 8'h48, 8'h00, 1'b0, r);
        chk("control reset", 8'h00, r);
        lk(1'b1, 8'h43, 8'h3F, 1'b0, r);
        lk(1'b0, 8'h43, 8'h00, 1'b0, r);
        chk("fixed source", 8'h18, r);
        apb(1'b0, 12'h00C, 32'h0, q, e);
        chk("unmapped", 1'b1, e);
        lk(1'b0, `IFLP_OFF_SWACK, 8'h00, 1'b1, r);
        chk("level 0 ack", 24, r);
        $display("test reset_refuse done");
        for (int rd = 0; rd < 6; rd++)
        begin
            k = $urandom % 7;
            src <= '0;
            lvin <= '0;
            repeat (4) @(posedge clk);
            for (int s = 8; s < 64; s++)
            begin
                lv[s] = (rd == 0) ? 0 : ((s - 8) / 8 + k) % 7 + 1;
                pr[s] = (s + k) % 8;
                lk(1'b1, 8'(8'h40 + s), {2'b00, lv[s][2:0], pr[s][2:0]}, 1'b0, r);
            end
            lk(1'b0, 8'h7F, 8'h00, 1'b0, r);
            chk("control byte", {2'b00, lv[63][2:0], pr[63][2:0]}, r);
            mreg = {$urandom, $urandom} & {$urandom, $urandom};
            mreg[0] = ($urandom % 4 == 0);
            for (int b = 0; b < 8; b++)
                lk(1'b1, 8'(8'h08 + b), mreg[8 * b +: 8], 1'b0, r);
            src <= 63'({$urandom, $urandom});
            lvin <= 7'($urandom & $urandom & $urandom);
            repeat (4) @(posedge clk);
            chk("level out", dec(), lvout);
            pv = {src & ~mreg[63:1] & {63{~mreg[0]}}, 1'b0};
            chk("wake", |pv, wake);
            n = $urandom % 8;
            lk(1'b0, 8'(n), 8'h00, 1'b0, r);
            chk("pending", pv[8 * n +: 8], r);
            lk(1'b0, `IFLP_OFF_LVL, 8'h00, 1'b0, r);
            chk("decoded", {dec(), 1'b0}, r);
            apb(1'b0, `IFLP_APB_STAT, 32'h0, q, e);
            chk("ipl", top(dec() | lvin), q[18:16]);
            lk(1'b0, `IFLP_OFF_SWACK, 8'h00, 1'b0, r);
            chk("sw ack", vec(top(dec())), r);
            for (int i = 1; i < 8; i++)
            begin
                lk(1'b0, 8'(8'hE0 + 4 * i), 8'h00, 1'b0, r);
                chk("level ack", vec(i), r);
                lk(1'b0, 8'(8'hE0 + 4 * i), 8'h00, 1'b1, r);
                chk("hw ack", vec(i), r);
            end
            m = $urandom % 8;
            l = top(dec() | lvin);
            apb(1'b1, `IFLP_APB_SRMASK, 32'(m) << 8, q, e);
            for (int p = 0; p < 2; p++)
            begin
                tk = (p == 0) && (l == 7 || l > m);
                insn <= 1'b1;
                @(posedge clk);
                insn <= 1'b0;
                n = 0;
                while (exc !== 1'b1 && n < 20)
                begin
                    @(posedge clk);
                    n++;
                end
                chk("taken", tk, n < 20);
                if (tk != 0) chk("vector", vec(l), excv);
            end
            $display("test round %0d done", rd);
        end
        results();
    end
endmodule
`default_nettype wire
